/* File: rtl/tdsa_timer.sv */
// Timer core: counter, three channels, modulator, register port.
// Assumes pins and radio events are asynchronous and a tick enable is given.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "tdsa_defs.svh"

module tdsa_timer
    import tdsa_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    input  wire logic       tick_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [2:0] chan_pin_in,
    input  wire logic       radio_event,
    output logic      [2:0] chan_pin_out,
    output logic      [2:0] chan_pin_oe,
    output logic            chan0_dma_request,
    output logic            chan1_dma_request,
    output logic            chan2_dma_request
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] cnt_reg;
    logic [7:0]  cnth_latch_reg;
    logic [3:0]  pend_reg;
    logic [1:0]  div_reg;
    tdsa_mode_t  mode_reg;
    tdsa_dir_t   dir_reg;
    logic [7:0]  cctl_reg [3];
    logic [15:0] ccv_reg [3];
    logic [7:0]  ccl_shadow_reg [3];
    logic [6:0]  pre_reg;
    logic [2:0]  pin_s1_reg;
    logic [2:0]  pin_s2_reg;
    logic [2:0]  pin_d_reg;
    logic        rf_s1_reg;
    logic        rf_s2_reg;
    logic        rf_d_reg;
    logic [2:0]  out_reg;
    logic [7:0]  rdata_reg;

    logic        dsm_on;
    logic        step;
    logic        at_top;
    logic        turn_zero;
    logic [15:0] top_val;
    logic [2:0]  chan_evt;
    logic        ovf_evt;
    logic [2:0]  cap_evt;
    logic [2:0]  cmp_evt;
    logic        pre_tick;
    logic        dsm_out;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    assign dsm_on = cctl_reg[1][5:3] == `TDSA_CMP_DSM;

    // ------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_reg <= 7'h00;
        end else if (clk_en && tick_en) begin
            pre_reg <= pre_reg + 7'h01;
        end
    end

    always_comb begin
        case (div_reg)
            2'h0:    pre_tick = 1'b1;
            2'h1:    pre_tick = pre_reg[2:0] == 3'h7;
            2'h2:    pre_tick = pre_reg[4:0] == 5'h1f;
            default: pre_tick = pre_reg == `TDSA_PRE_MAX;
        endcase
    end

    // ------------------------------------------------------------------
    // Counter decode
    // ------------------------------------------------------------------
    // Modulator bypasses the prescaler
    assign step = tick_en && (dsm_on || pre_tick) && mode_reg != TDSA_MODE_STOP;
    assign top_val = (mode_reg == TDSA_MODE_FREE) ? 16'hffff : ccv_reg[0];
    assign at_top = cnt_reg == top_val;
    assign turn_zero = mode_reg == TDSA_MODE_UPDN && dir_reg == TDSA_DIR_DOWN
                       && cnt_reg == 16'h0001;
    assign ovf_evt = step && (mode_reg == TDSA_MODE_UPDN ? turn_zero : at_top);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 16'h0000;
            dir_reg <= TDSA_DIR_UP;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `TDSA_CNTL_ADDR) begin
                cnt_reg <= 16'h0000;
                dir_reg <= TDSA_DIR_UP;
            end else if (step) begin
                if (mode_reg == TDSA_MODE_UPDN) begin
                    if (dir_reg == TDSA_DIR_UP && at_top) begin
                        dir_reg <= TDSA_DIR_DOWN;
                        cnt_reg <= cnt_reg - 16'h0001;
                    end else if (dir_reg == TDSA_DIR_DOWN && cnt_reg == 16'h0000) begin
                        dir_reg <= TDSA_DIR_UP;
                        cnt_reg <= 16'h0001;
                    end else if (dir_reg == TDSA_DIR_DOWN) begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end else begin
                        cnt_reg <= cnt_reg + 16'h0001;
                    end
                end else begin
                    cnt_reg <= at_top ? 16'h0000 : cnt_reg + 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
            pin_d_reg  <= 3'h0;
            rf_s1_reg  <= 1'b0;
            rf_s2_reg  <= 1'b0;
            rf_d_reg   <= 1'b0;
        end else if (clk_en) begin
            pin_s1_reg <= chan_pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg  <= pin_s2_reg;
            rf_s1_reg  <= radio_event;
            rf_s2_reg  <= rf_s1_reg;
            rf_d_reg   <= rf_s2_reg;
        end
    end

    // ------------------------------------------------------------------
    // Channel events
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            logic cur;
            logic prv;
            cur = cctl_reg[i][7] ? rf_s2_reg : pin_s2_reg[i];
            prv = cctl_reg[i][7] ? rf_d_reg : pin_d_reg[i];
            cap_evt[i] = !cctl_reg[i][2] && !(i == 1 && dsm_on)
                         && ((cctl_reg[i][0] && cur && !prv)
                          || (cctl_reg[i][1] && !cur && prv));
            cmp_evt[i] = cctl_reg[i][2] && step && cnt_reg == ccv_reg[i];
            chan_evt[i] = cap_evt[i] || cmp_evt[i];
        end
        // Up/down compare on channel 0 flags at zero turnaround
        if (mode_reg == TDSA_MODE_UPDN && cctl_reg[0][2]) begin
            chan_evt[0] = ovf_evt;
        end
    end

    assign chan0_dma_request = chan_evt[0];
    assign chan1_dma_request = chan_evt[1];
    assign chan2_dma_request = chan_evt[2];

    // ------------------------------------------------------------------
    // Control, status and pending flags
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_reg <= 4'h0;
            div_reg  <= 2'h0;
            mode_reg <= TDSA_MODE_STOP;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `TDSA_CTL_ADDR) begin
                pend_reg <= (pend_reg & reg_wdata[7:4])
                          | {chan_evt[2], chan_evt[1], chan_evt[0], ovf_evt};
                div_reg  <= reg_wdata[3:2];
                mode_reg <= tdsa_mode_t'(reg_wdata[1:0]);
            end else begin
                pend_reg <= pend_reg | {chan_evt[2], chan_evt[1], chan_evt[0], ovf_evt};
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel control and value registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 3; i++) begin
                cctl_reg[i]       <= `TDSA_CCTL_RESET;
                ccv_reg[i]        <= 16'h0000;
                ccl_shadow_reg[i] <= 8'h00;
            end
        end else if (clk_en) begin
            for (int i = 0; i < 3; i++) begin
                if (reg_wr && reg_addr == `TDSA_CCTL0_ADDR + 8'(i)) begin
                    cctl_reg[i] <= reg_wdata;
                end
                if (reg_wr && reg_addr == `TDSA_CC0L_ADDR + 8'(2 * i)) begin
                    ccl_shadow_reg[i] <= reg_wdata;
                end else if (reg_wr && reg_addr == `TDSA_CC0H_ADDR + 8'(2 * i)) begin
                    ccv_reg[i] <= {reg_wdata, ccl_shadow_reg[i]};
                end else if (cap_evt[i]) begin
                    ccv_reg[i] <= cnt_reg;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Compare outputs
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_reg <= 3'h0;
        end else if (clk_en) begin
            for (int i = 0; i < 3; i++) begin
                if (cctl_reg[i][2] && step) begin
                    case (cctl_reg[i][5:3])
                        3'h0: if (cmp_evt[i]) out_reg[i] <= 1'b1;
                        3'h1: if (cmp_evt[i]) out_reg[i] <= 1'b0;
                        3'h2: if (cmp_evt[i]) out_reg[i] <= !out_reg[i];
                        3'h3, 3'h4: begin
                            if (cmp_evt[i]) begin
                                out_reg[i] <= (dir_reg == TDSA_DIR_UP) ^ cctl_reg[i][5];
                            end else if (cnt_reg == 16'h0000) begin
                                out_reg[i] <= cctl_reg[i][5];
                            end
                        end
                        3'h5, 3'h6: begin
                            if (i != 0 && cmp_evt[i]) begin
                                out_reg[i] <= !cctl_reg[i][4];
                            end else if (i != 0 && cnt_reg == ccv_reg[0]) begin
                                out_reg[i] <= cctl_reg[i][4];
                            end
                        end
                        default: out_reg[i] <= out_reg[i];
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    assign chan_pin_out = {out_reg[2], dsm_on ? dsm_out : out_reg[1], out_reg[0]};
    assign chan_pin_oe  = {cctl_reg[2][2], cctl_reg[1][2] | dsm_on, cctl_reg[0][2]};

    // ------------------------------------------------------------------
    // Noise-shaping modulator
    // ------------------------------------------------------------------
    logic [2:0]  dsm_phase_reg;
    logic signed [17:0] smp_reg;
    logic signed [17:0] smp_prev_reg;
    logic signed [17:0] interp_reg;
    logic signed [21:0] int1_reg;
    logic signed [21:0] int2_reg;
    logic        bit_reg;
    logic        dsm_upd;
    logic        new_smp;
    logic signed [17:0] smp_in;
    logic signed [21:0] fb;
    logic signed [21:0] int1_nx;
    logic signed [21:0] int2_nx;
    logic signed [17:0] drive;

    assign smp_in  = 18'(signed'({ccv_reg[1][15:2], 2'b00}));
    assign new_smp = step && at_top;
    assign dsm_upd = tick_en && (cctl_reg[1][2] ? dsm_phase_reg[1:0] == 2'h3
                                                : dsm_phase_reg == 3'h7);
    assign drive   = cctl_reg[1][1] ? smp_reg : interp_reg;
    assign fb      = bit_reg ? 22'sh008000 : -22'sh008000;
    assign int1_nx = int1_reg + 22'(drive) - fb;
    assign int2_nx = int2_reg + int1_nx - fb;

    // ------------------------------------------------------------------
    // Modulator state
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dsm_phase_reg <= 3'h0;
            smp_reg       <= 18'sh0;
            smp_prev_reg  <= 18'sh0;
            interp_reg    <= 18'sh0;
            int1_reg      <= 22'sh0;
            int2_reg      <= 22'sh0;
            bit_reg       <= 1'b0;
        end else if (clk_en) begin
            if (!dsm_on) begin
                dsm_phase_reg <= 3'h0;
                smp_reg       <= smp_in;
                smp_prev_reg  <= smp_in;
                interp_reg    <= smp_in;
                int1_reg      <= 22'sh0;
                int2_reg      <= 22'sh0;
            end else begin
                if (tick_en) begin
                    dsm_phase_reg <= dsm_phase_reg + 3'h1;
                end
                if (new_smp) begin
                    smp_prev_reg <= smp_reg;
                    smp_reg      <= smp_in;
                    interp_reg   <= smp_reg;
                end else if (dsm_upd) begin
                    // First-order ramp, step scaled by period length
                    interp_reg <= interp_reg + 18'((smp_reg - smp_prev_reg)
                                  >>> (cctl_reg[1][2] ? 4'd2 : 4'd3));
                end
                if (dsm_upd) begin
                    int1_reg <= int1_nx;
                    int2_reg <= int2_nx;
                    // Quantise the new state; an extra loop delay is unstable
                    bit_reg  <= !int2_nx[21];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Shaper: first phase low, last phase high, bit value between
    // ------------------------------------------------------------------
    logic last_ph;
    logic first_ph;
    assign first_ph = cctl_reg[1][2] ? dsm_phase_reg[1:0] == 2'h0 : dsm_phase_reg == 3'h0;
    assign last_ph  = cctl_reg[1][2] ? dsm_phase_reg[1:0] == 2'h3 : dsm_phase_reg == 3'h7;
    assign dsm_out  = cctl_reg[1][0] ? bit_reg
                    : (first_ph ? 1'b0 : (last_ph ? 1'b1 : bit_reg));

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg      <= 8'h00;
            cnth_latch_reg <= 8'h00;
        end else if (clk_en && reg_rd) begin
            case (reg_addr)
                `TDSA_CC0L_ADDR:  rdata_reg <= ccv_reg[0][7:0];
                `TDSA_CC0H_ADDR:  rdata_reg <= ccv_reg[0][15:8];
                `TDSA_CC1L_ADDR:  rdata_reg <= ccv_reg[1][7:0];
                `TDSA_CC1H_ADDR:  rdata_reg <= ccv_reg[1][15:8];
                `TDSA_CC2L_ADDR:  rdata_reg <= ccv_reg[2][7:0];
                `TDSA_CC2H_ADDR:  rdata_reg <= ccv_reg[2][15:8];
                `TDSA_CNTL_ADDR: begin
                    rdata_reg      <= cnt_reg[7:0];
                    cnth_latch_reg <= cnt_reg[15:8];
                end
                `TDSA_CNTH_ADDR:  rdata_reg <= cnth_latch_reg;
                `TDSA_CTL_ADDR:   rdata_reg <= {pend_reg, div_reg, mode_reg};
                `TDSA_CCTL0_ADDR: rdata_reg <= cctl_reg[0];
                `TDSA_CCTL1_ADDR: rdata_reg <= cctl_reg[1];
                `TDSA_CCTL2_ADDR: rdata_reg <= cctl_reg[2];
                default:          rdata_reg <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_reg;

endmodule

`default_nettype wire

/* File: pkg/tdsa_defs.svh */
// Constants for the 16-bit timer with noise-shaping audio modulator.
// Assumes an 8-bit register port and a 125 MHz core clock.
`ifndef TDSA_DEFS_SVH
`define TDSA_DEFS_SVH
`define TDSA_CC0L_ADDR   8'hda
`define TDSA_CC0H_ADDR   8'hdb
`define TDSA_CC1L_ADDR   8'hdc
`define TDSA_CC1H_ADDR   8'hdd
`define TDSA_CC2L_ADDR   8'hde
`define TDSA_CC2H_ADDR   8'hdf
`define TDSA_CNTL_ADDR   8'he2
`define TDSA_CNTH_ADDR   8'he3
`define TDSA_CTL_ADDR    8'he4
`define TDSA_CCTL0_ADDR  8'he5
`define TDSA_CCTL1_ADDR  8'he6
`define TDSA_CCTL2_ADDR  8'he7
`define TDSA_CCTL_RESET  8'h40
`define TDSA_CTL_RESET   8'h00
`define TDSA_CMP_DSM     3'h7
`define TDSA_PRE_MAX     7'h7f
`endif

/* File: pkg/tdsa_pkg.sv */
// Types for the timer with noise-shaping modulator.
// Assumes tdsa_defs.svh supplies the numeric constants.
package tdsa_pkg;
    typedef enum logic [1:0] {
        TDSA_MODE_STOP = 2'h0,
        TDSA_MODE_FREE = 2'h1,
        TDSA_MODE_MOD  = 2'h2,
        TDSA_MODE_UPDN = 2'h3
    } tdsa_mode_t;
    typedef enum logic [1:0] {
        TDSA_DIR_UP   = 2'h1,
        TDSA_DIR_DOWN = 2'h2
    } tdsa_dir_t;
endpackage

/* File: tb/tdsa_far_side.sv */
// Far-side model: channel pins, radio events, DMA request counter.
// Assumes the bench calls its tasks; one core clock.
`timescale 1ns/1ns
`default_nettype none

module tdsa_far_side (
    input  wire logic       core_clk,
    input  wire logic [2:0] dma_req,
    output logic      [2:0] pin_drive,
    output logic            radio_pulse
);
    int unsigned dma_count [3] = '{0, 0, 0};

    initial begin
        pin_drive = 3'h0;
        radio_pulse = 1'b0;
    end

    // DMA controller side: one transfer per request pulse
    always @(posedge core_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (dma_req[i]) begin
                dma_count[i]++;
            end
        end
    end

    // Pin level held long past the synchroniser
    task automatic set_pin(input int ch, input logic lvl);
        @(posedge core_clk);
        pin_drive[ch] <= lvl;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic radio_blip();
        @(posedge core_clk);
        radio_pulse <= 1'b1;
        repeat (4) @(posedge core_clk);
        radio_pulse <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask
endmodule

`default_nettype wire

/* File: tb/tdsa_timer_properties.sv */
// Port checker for the timer core, bound to tdsa_timer.
// Assumes register writes are taken only with clk_en high.
`timescale 1ns/1ns
`default_nettype none

module tdsa_timer_chk (
    input wire logic       core_clk,
    input wire logic       arst_n,
    input wire logic       clk_en,
    input wire logic       tick_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] chan_pin_in,
    input wire logic       radio_event,
    input wire logic [2:0] chan_pin_out,
    input wire logic [2:0] chan_pin_oe,
    input wire logic       chan0_dma_request,
    input wire logic       chan1_dma_request,
    input wire logic       chan2_dma_request
);
    logic [7:0] c0;
    logic [7:0] c1;
    logic [3:0] ctl;
    logic [4:0] run;
    logic       o1d;
    wire        wr  = reg_wr && clk_en;
    wire        rd  = reg_rd && clk_en;
    wire        shp = c1[5:3] == 3'h7 && !c1[0] && tick_en && clk_en;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // ----------------------------------------
    // Register shadows and shaper gap counter
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            c0 <= 8'h40;
            c1 <= 8'h40;
            ctl <= 4'h0;
        end else if (wr && reg_addr == 8'he5) begin
            c0 <= reg_wdata;
        end else if (wr && reg_addr == 8'he6) begin
            c1 <= reg_wdata;
        end else if (wr && reg_addr == 8'he4) begin
            ctl <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            o1d <= 1'b0;
            run <= 5'h0;
        end else begin
            o1d <= chan_pin_out[1];
            if (!shp || (chan_pin_out[1] && !o1d)) begin
                run <= 5'h0;
            end else if (run != 5'h1f) begin
                run <= run + 5'h1;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_rdata_holds: assert property (!$past(rd) |-> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctl_readback: assert property (
        rd && reg_addr == 8'he4 |=> reg_rdata[3:0] == $past(ctl))
        else $error("status divider or mode readback wrong");
    a_ctl0_readback: assert property (
        rd && reg_addr == 8'he5 |=> reg_rdata == $past(c0))
        else $error("channel 0 control readback wrong");
    a_oe_compare: assert property (c0[2] [*2] |-> chan_pin_oe[0])
        else $error("channel 0 compare pin not driven");
    a_oe_capture: assert property (!c0[2] [*2] |-> !chan_pin_oe[0])
        else $error("channel 0 capture pin driven");
    a_dsm_drives: assert property ((c1[5:3] == 3'h7) [*2] |-> chan_pin_oe[1])
        else $error("modulator pin not driven");
    a_shaper_edges: assert property (run <= 5'd20)
        else $error("shaped modulator output missed a rising edge");
    a_dma_single: assert property (chan2_dma_request |=> !chan2_dma_request)
        else $error("channel 2 request longer than one cycle");

    c_dma0: cover property (chan0_dma_request);
    c_dsm_out: cover property (c1[5:3] == 3'h7 && chan_pin_out[1]);
    c_cnt_read: cover property (rd && reg_addr == 8'he2);
endmodule

bind tdsa_timer tdsa_timer_chk u_chk (.core_clk, .arst_n, .clk_en, .tick_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chan_pin_in, .radio_event, .chan_pin_out,
    .chan_pin_oe, .chan0_dma_request, .chan1_dma_request, .chan2_dma_request);

`default_nettype wire

/* File: tb/timer16_delta_sigma_audio_tb.sv */
// Self-checking bench for the timer core with modulator.
// Assumes tdsa_far_side and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none

module timer16_delta_sigma_audio_tb;
    logic       core_clk, arst_n, clk_en, tick_en, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, v;
    wire  [7:0] reg_rdata;
    wire  [2:0] pin_in, pin_out, pin_oe, dma;
    wire        radio;
    int         fails = 0;
    int         checks_done = 0;

    tdsa_timer uut (.core_clk, .arst_n, .clk_en, .tick_en, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .chan_pin_in(pin_in), .radio_event(radio),
        .chan_pin_out(pin_out), .chan_pin_oe(pin_oe), .chan0_dma_request(dma[0]),
        .chan1_dma_request(dma[1]), .chan2_dma_request(dma[2]));
    tdsa_far_side far (.core_clk, .dma_req(dma), .pin_drive(pin_in), .radio_pulse(radio));

    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(what, {8'h0, d}, {8'h0, exp});
    endtask

    task automatic rises(input int n, output int r);
        logic p;
        r = 0;
        #1 p = pin_out[1];
        repeat (n) begin
            @(posedge core_clk);
            #1 if (pin_out[1] && !p) r++;
            p = pin_out[1];
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rchk("ctl0", 8'he5, 8'h40);
        rchk("ctl1", 8'he6, 8'h40);
        rchk("status", 8'he4, 8'h00);
        rchk("unmapped", 8'h00, 8'h00);
        wr(8'he3, 8'h55);
        rchk("cnt_hi_ro", 8'he3, 8'h00);
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(8'he5, 8'h00);
        clk_en <= 1'b1;
        rchk("frozen_write", 8'he5, 8'h40);
        $display("test reset done");
    endtask

    task automatic t_count();
        int e;
        wr(8'he4, 8'h01);
        repeat (40) @(posedge core_clk);
        wr(8'he4, 8'h00);
        wr(8'he2, 8'ha5);
        rchk("clear_lo", 8'he2, 8'h00);
        wr(8'he4, 8'h01);
        repeat (100) @(posedge core_clk);
        rd(8'he2, v);
        repeat (300) @(posedge core_clk);
        rchk("latched_hi", 8'he3, 8'h00);
        for (int k = 0; k < 4; k++) begin
            e = 202 >> ((k == 0) ? 0 : 1 + 2 * k);
            wr(8'he4, {4'h0, 2'(k), 2'h0});
            wr(8'he2, 8'h00);
            wr(8'he4, {4'h0, 2'(k), 2'h1});
            repeat (200) @(posedge core_clk);
            wr(8'he4, 8'h00);
            rd(8'he2, v);
            chk("prescale", 16'(int'(v) >= e - 2 && int'(v) <= e + 2), 16'h1);
            repeat (20) @(posedge core_clk);
            rchk("suspended", 8'he2, v);
        end
        $display("test count done");
    endtask

    task automatic t_ovf();
        int unsigned n;
        logic [2:0] ovf_exp = 3'b110;
        wr(8'hda, 8'h10);
        wr(8'hdb, 8'h00);
        wr(8'he5, 8'h54);
        for (int m = 1; m < 4; m++) begin
            wr(8'he4, 8'h00);
            wr(8'he2, 8'h00);
            n = far.dma_count[0];
            wr(8'he4, {6'h0, 2'(m)});
            repeat (100) @(posedge core_clk);
            rd(8'he4, v);
            chk("overflow", {15'h0, v[4]}, {15'h0, ovf_exp[m - 1]});
        end
        wr(8'he4, 8'h02);
        wr(8'he2, 8'h00);
        n = far.dma_count[0];
        repeat (100) @(posedge core_clk);
        chk("dma0", 16'(far.dma_count[0] - n >= 4 && far.dma_count[0] - n <= 7), 16'h1);
        chk("oe0", {15'h0, pin_oe[0]}, 16'h1);
        rd(8'he4, v);
        chk("flags", {10'h0, v[5:0]}, 16'h32);
        wr(8'he4, 8'h00);
        rchk("cleared", 8'he4, 8'h00);
        wr(8'he4, 8'hf0);
        rchk("w1_ignored", 8'he4, 8'h00);
        $display("test overflow done");
    endtask

    task automatic t_capture();
        int unsigned n;
        int exp [4] = '{0, 1, 1, 2};
        wr(8'he4, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(8'he7, {6'h10, 2'(k)});
            n = far.dma_count[2];
            far.set_pin(2, 1'b1);
            far.set_pin(2, 1'b0);
            chk("capture_edge", 16'(far.dma_count[2] - n), 16'(exp[k]));
        end
        rd(8'he4, v);
        chk("ch2_flag", {15'h0, v[7]}, 16'h1);
        wr(8'he6, 8'hc1);
        n = far.dma_count[1];
        far.set_pin(1, 1'b1);
        far.set_pin(1, 1'b0);
        far.radio_blip();
        chk("radio_capture", 16'(far.dma_count[1] - n), 16'h1);
        $display("test capture done");
    endtask

    task automatic t_dsm();
        int r;
        wr(8'he4, 8'h00);
        wr(8'he2, 8'h00);
        wr(8'hda, 8'h10);
        wr(8'hdb, 8'h00);
        wr(8'he5, 8'h44);
        wr(8'hdc, 8'h00);
        wr(8'hdd, 8'h00);
        wr(8'he4, 8'h0e);
        wr(8'he6, 8'h40);
        wr(8'he6, 8'h78);
        rises(80, r);
        chk("shaped_eighth", 16'(r >= 9), 16'h1);
        chk("oe1", {15'h0, pin_oe[1]}, 16'h1);
        wr(8'he6, 8'h7e);
        rises(80, r);
        chk("shaped_quarter", 16'(r >= 18), 16'h1);
        wr(8'hdc, 8'h00);
        wr(8'hdd, 8'h70);
        wr(8'he6, 8'h7b);
        repeat (120) @(posedge core_clk);
        rises(80, r);
        chk("unshaped_full", 16'(r <= 3), 16'h1);
        $display("test modulator done");
    endtask

    // ----------------------------------------
    // Verdict, clock, watchdog, main sequence
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        repeat (30000) @(posedge core_clk);
        fails++;
        give_verdict();
    end

    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        tick_en = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset();
        t_count();
        t_ovf();
        t_capture();
        t_dsm();
        give_verdict();
    end
endmodule

`default_nettype wire
